// file: link_bank_pkg.sv
// package with register map, error codes, types and timing for the link status bank
package link_bank_pkg;

  // ---------------------------------------------------------------
  // register byte offsets (two channels, channel 2 at +0x40)
  // ---------------------------------------------------------------
  localparam logic [11:0] ch_stride = 12'h040;
  localparam logic [11:0] off_flags = 12'h000;
  localparam logic [11:0] off_control = 12'h004;
  localparam logic [11:0] off_error_code = 12'h008;
  localparam logic [11:0] off_format = 12'h00c;
  localparam logic [11:0] off_station = 12'h010;
  localparam logic [11:0] off_head = 12'h014;
  localparam logic [11:0] off_count = 12'h018;
  localparam logic [11:0] off_timeout = 12'h01c;
  localparam logic [11:0] off_regs_used = 12'h020;
  localparam logic [11:0] off_retain = 12'h080;

  // ---------------------------------------------------------------
  // flag register bit positions
  // ---------------------------------------------------------------
  localparam int bit_link_error = 0;
  localparam int bit_global = 1;
  localparam int bit_busy = 2;
  localparam int bit_od_error = 3;
  localparam int bit_unit_select = 4;
  // control register: bit 0 unit select, bit 1 send request (write 1), bit 2 clear on-demand error (write 1)
  localparam int bit_ctl_unit = 0;
  localparam int bit_ctl_send = 1;
  localparam int bit_ctl_clr_od = 2;

  // ---------------------------------------------------------------
  // error codes per channel, decimal figures written as bcd words
  // ---------------------------------------------------------------
  localparam logic [15:0] code_frame_ch1 = 16'h6301;
  localparam logic [15:0] code_command_ch1 = 16'h6305;
  localparam logic [15:0] code_timeout_ch1 = 16'h6306;
  localparam logic [15:0] code_frame_ch2 = 16'h3801;
  localparam logic [15:0] code_command_ch2 = 16'h3805;
  localparam logic [15:0] code_timeout_ch2 = 16'h3806;
  localparam logic [7:0] broadcast_station = 8'hff;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] word_reset = 16'h0000;
  localparam logic [15:0] od_count_max = 16'h0100;
  localparam int tick_time_us = 10;
  localparam int clk_rate_mhz = 25;
  localparam int tick_cycles = tick_time_us * clk_rate_mhz;
  localparam logic [15:0] tick_cycles_w = 16'(tick_cycles);

  // link-side events for one channel, reported by the framing logic
  typedef struct packed {
    logic frame_fault;
    logic cmd_valid;
    logic [7:0] cmd_station;
    logic cmd_is_global_write;
    logic global_value;
    logic rx_active;
    logic msg_done;
  } link_event_t;

  // on-demand sender handshake for one channel
  typedef struct packed {
    logic start;
    logic unit_byte;
    logic [15:0] head;
    logic [15:0] regs;
  } od_request_t;

  typedef enum logic [1:0] {
    od_idle = 2'b00,
    od_send = 2'b01
  } od_state_t;

endpackage

// file: link_status_error_bank.sv
// apb register bank holding link status, error codes and settings of a two-channel link responder
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// [R1] channel 1 bad message sets channel 1 link error flag
// [R2] channel 2 bad message sets channel 2 link error flag
// [R3] setting a link error flag writes its code into the channel error word
// [R4] parity, overrun or framing fault records 6301 or 3801
// [R5] broadcast station ff with a non global write records 6305 or 3805
// [R6] reception timeout restarts the sequence and records 6306 or 3806
// [R7] error codes survive error resets, cleared only on stop to run
// [R8] global write sets or clears the read-only global flag
// [R9] busy flag stays high while on-demand data is sent
// [R10] invalid on-demand count sets the on-demand error flag
// [R11] unit select set means byte units, clear means word units
// [R12] read/write station number word per channel
// [R13] read/write on-demand head and quantity words per channel
// [R14] read/write timeout time word per channel
// [R15] read/write communication format word per channel
// [R16] read/write setting retention bit keeps format and station
// [R17] link error flag stays set until stop to run
// [R18] global flag forced off on power-down or change to stop
// [R19] on-demand send refused while on-demand error flag is set
// [R20] byte mode packs two items per register, rounding up
// [R21] reset clears flags and codes before reception is enabled
module link_status_error_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_mode,
  input wire logic power_down,
  input wire link_bank_pkg::link_event_t [1:0] link_event,
  output logic [1:0] rx_enable,
  output logic [1:0] rx_restart,
  output link_bank_pkg::od_request_t [1:0] od_request,
  input wire logic [1:0] od_done,
  output logic [1:0] retain_settings
);

  // ---------------------------------------------------------------
  // bus decode and mode tracking
  // ---------------------------------------------------------------
  logic wr_en;
  logic [11:0] ch_addr;
  logic ch_sel;
  logic ch_hit;
  logic run_reg;
  logic stop_to_run;
  logic to_stop;
  logic ready_reg;
  logic retain_reg;
  logic [15:0] tick_reg;
  logic tick;

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign ch_sel = paddr[6];
  assign ch_addr = paddr & ~link_bank_pkg::ch_stride;
  assign ch_hit = (paddr < (link_bank_pkg::ch_stride << 1)) && (ch_addr < link_bank_pkg::off_regs_used);
  assign pslverr = psel && penable && !ch_hit && (paddr != link_bank_pkg::off_retain);
  assign stop_to_run = run_mode && !run_reg;
  assign to_stop = !run_mode && run_reg;
  assign tick = (tick_reg == link_bank_pkg::tick_cycles_w - 16'h0001);
  assign rx_enable = {ready_reg, ready_reg};
  assign retain_settings = {retain_reg, retain_reg};

  // previous mode for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= run_mode;
    end
  end

  // [R21] reception enabled one cycle after clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= 1'b1;
    end
  end

  // free running prescaler giving the timeout time base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= link_bank_pkg::word_reset;
    end else if (tick) begin
      tick_reg <= link_bank_pkg::word_reset;
    end else begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end

  // [R16] retention bit, software owned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retain_reg <= 1'b0;
    end else if (wr_en && paddr == link_bank_pkg::off_retain) begin
      retain_reg <= pwdata[0];
    end
  end

  // ---------------------------------------------------------------
  // per-channel state
  // ---------------------------------------------------------------
  logic [1:0] link_err_reg;
  logic [1:0] global_reg;
  logic [1:0] busy_reg;
  logic [1:0] od_err_reg;
  logic [1:0] unit_reg;
  logic [15:0] code_reg [2];
  logic [15:0] format_reg [2];
  logic [15:0] station_reg [2];
  logic [15:0] head_reg [2];
  logic [15:0] count_reg [2];
  logic [15:0] timeout_reg [2];
  logic [15:0] wait_reg [2];
  logic [31:0] rd_ch [2];

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      logic sel;
      logic wr;
      logic bad_cmd;
      logic time_out;
      logic fault;
      logic [15:0] code_next;
      logic [15:0] regs_next;
      logic send_req;
      logic clr_od;
      logic count_bad;

      assign sel = (ch_sel == 1'(c)) && ch_hit;
      assign wr = wr_en && sel;
      // [R5] broadcast station with anything but a global write
      assign bad_cmd = link_event[c].cmd_valid && link_event[c].cmd_station == link_bank_pkg::broadcast_station
                       && !link_event[c].cmd_is_global_write;
      // [R6] timeout counted in ticks while a message is partly received
      assign time_out = link_event[c].rx_active && timeout_reg[c] != link_bank_pkg::word_reset
                        && wait_reg[c] >= timeout_reg[c];
      assign fault = link_event[c].frame_fault || bad_cmd || time_out;
      assign rx_restart[c] = time_out;
      assign send_req = wr && ch_addr == link_bank_pkg::off_control && pwdata[link_bank_pkg::bit_ctl_send];
      assign clr_od = wr && ch_addr == link_bank_pkg::off_control && pwdata[link_bank_pkg::bit_ctl_clr_od];
      // [R10] zero or oversized quantity is invalid
      assign count_bad = count_reg[c] == link_bank_pkg::word_reset || count_reg[c] > link_bank_pkg::od_count_max;
      // [R20] byte units: two per register, rounded up; [R11] word units: one each
      assign regs_next = unit_reg[c] ? ((count_reg[c] + 16'h0001) >> 1) : count_reg[c];

      // lowest code wins when several faults coincide
      always_comb begin
        code_next = code_reg[c];
        if (link_event[c].frame_fault) begin
          // [R4] framing class code
          code_next = c ? link_bank_pkg::code_frame_ch2 : link_bank_pkg::code_frame_ch1;
        end else if (bad_cmd) begin
          code_next = c ? link_bank_pkg::code_command_ch2 : link_bank_pkg::code_command_ch1;
        end else if (time_out) begin
          code_next = c ? link_bank_pkg::code_timeout_ch2 : link_bank_pkg::code_timeout_ch1;
        end
      end

      // reception watchdog, restarted at the end of each message
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wait_reg[c] <= link_bank_pkg::word_reset;
        end else if (!link_event[c].rx_active || link_event[c].msg_done || time_out) begin
          wait_reg[c] <= link_bank_pkg::word_reset;
        end else if (tick && wait_reg[c] != 16'hffff) begin
          wait_reg[c] <= wait_reg[c] + 16'h0001;
        end
      end

      // [R1] [R2] [R17] sticky link error, a new fault wins over the clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          link_err_reg[c] <= 1'b0;
        end else if (fault) begin
          link_err_reg[c] <= 1'b1;
        end else if (stop_to_run) begin
          link_err_reg[c] <= 1'b0;
        end
      end

      // [R3] [R7] code stored with the flag, cleared only on stop to run
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          code_reg[c] <= link_bank_pkg::word_reset;
        end else if (fault) begin
          code_reg[c] <= code_next;
        end else if (stop_to_run) begin
          code_reg[c] <= link_bank_pkg::word_reset;
        end
      end

      // [R8] [R18] global flag follows the command, forced off at stop
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          global_reg[c] <= 1'b0;
        end else if (power_down || to_stop) begin
          global_reg[c] <= 1'b0;
        end else if (link_event[c].cmd_valid && link_event[c].cmd_is_global_write) begin
          global_reg[c] <= link_event[c].global_value;
        end
      end

      // [R9] [R19] busy from accepted request until sender reports done
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          busy_reg[c] <= 1'b0;
        end else if (busy_reg[c] && od_done[c]) begin
          busy_reg[c] <= 1'b0;
        end else if (send_req && !busy_reg[c] && !od_err_reg[c] && !count_bad) begin
          busy_reg[c] <= 1'b1;
        end
      end

      // [R10] on-demand error set by a bad request, set beats software clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          od_err_reg[c] <= 1'b0;
        end else if (send_req && !busy_reg[c] && count_bad) begin
          od_err_reg[c] <= 1'b1;
        end else if (clr_od) begin
          od_err_reg[c] <= 1'b0;
        end
      end

      // [R11] [R12] [R13] [R14] [R15] software setting words
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          unit_reg[c] <= 1'b0;
          format_reg[c] <= link_bank_pkg::word_reset;
          station_reg[c] <= link_bank_pkg::word_reset;
          head_reg[c] <= link_bank_pkg::word_reset;
          count_reg[c] <= link_bank_pkg::word_reset;
          timeout_reg[c] <= link_bank_pkg::word_reset;
        end else if (wr) begin
          case (ch_addr)
            link_bank_pkg::off_control: unit_reg[c] <= pwdata[link_bank_pkg::bit_ctl_unit];
            link_bank_pkg::off_format: format_reg[c] <= pwdata[15:0];
            link_bank_pkg::off_station: station_reg[c] <= pwdata[15:0];
            link_bank_pkg::off_head: head_reg[c] <= pwdata[15:0];
            link_bank_pkg::off_count: count_reg[c] <= pwdata[15:0];
            link_bank_pkg::off_timeout: timeout_reg[c] <= pwdata[15:0];
            default: unit_reg[c] <= unit_reg[c];
          endcase
        end
      end

      // request to the sender, registered data
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          od_request[c] <= '0;
        end else begin
          od_request[c].start <= send_req && !busy_reg[c] && !od_err_reg[c] && !count_bad;
          od_request[c].unit_byte <= unit_reg[c];
          od_request[c].head <= head_reg[c];
          od_request[c].regs <= regs_next;
        end
      end

      // read mux for this channel
      always_comb begin
        rd_ch[c] = 32'h0000_0000;
        case (ch_addr)
          link_bank_pkg::off_flags: begin
            rd_ch[c][link_bank_pkg::bit_link_error] = link_err_reg[c];
            rd_ch[c][link_bank_pkg::bit_global] = global_reg[c];
            rd_ch[c][link_bank_pkg::bit_busy] = busy_reg[c];
            rd_ch[c][link_bank_pkg::bit_od_error] = od_err_reg[c];
            rd_ch[c][link_bank_pkg::bit_unit_select] = unit_reg[c];
          end
          link_bank_pkg::off_control: rd_ch[c][link_bank_pkg::bit_ctl_unit] = unit_reg[c];
          link_bank_pkg::off_error_code: rd_ch[c][15:0] = code_reg[c];
          link_bank_pkg::off_format: rd_ch[c][15:0] = format_reg[c];
          link_bank_pkg::off_station: rd_ch[c][15:0] = station_reg[c];
          link_bank_pkg::off_head: rd_ch[c][15:0] = head_reg[c];
          link_bank_pkg::off_count: rd_ch[c][15:0] = count_reg[c];
          link_bank_pkg::off_timeout: rd_ch[c][15:0] = timeout_reg[c];
          default: rd_ch[c] = 32'h0000_0000;
        endcase
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read data register, loaded in the setup cycle so it is valid in access
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == link_bank_pkg::off_retain) begin
        prdata <= {31'h0000_0000, retain_reg};
      end else if (ch_hit) begin
        prdata <= rd_ch[ch_sel];
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule
`default_nettype wire

// file: link_bank_props.sv
// checker for the apb and sender ports of the link status bank
`timescale 1ns/10ps
`default_nettype none
module link_bank_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire link_bank_pkg::link_event_t [1:0] link_event,
  input wire logic [1:0] rx_enable,
  input wire logic [1:0] rx_restart,
  input wire link_bank_pkg::od_request_t [1:0] od_request,
  input wire logic [1:0] retain_settings
);
  // ----------------
  // decode helpers
  // ----------------
  logic wr;
  logic rd_set;
  logic hit;
  logic snd;
  logic ret_wr;
  logic [11:0] low;
  logic [1:0][15:0] cnt_reg;
  assign wr = psel && penable && pwrite;
  assign rd_set = psel && !penable && !pwrite;
  assign low = paddr & 12'h03f;
  assign hit = paddr == link_bank_pkg::off_retain || (paddr < 12'h080 && low < link_bank_pkg::off_regs_used);
  assign snd = wr && paddr == link_bank_pkg::off_control && pwdata[link_bank_pkg::bit_ctl_send];
  assign ret_wr = wr && paddr == link_bank_pkg::off_retain;
  // mirror of the quantity words, so the register count can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (wr && paddr < 12'h080 && low == link_bank_pkg::off_count) begin
      cnt_reg[paddr[6]] <= pwdata[15:0];
    end
  end
  // byte units need half the registers, rounded up
  function automatic logic [15:0] need(input logic b, input logic [15:0] c);
    return b ? 16'((17'(c) + 17'h1) >> 1) : c;
  endfunction
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------
  // properties
  // ----------------
  ready_now_a: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  slverr_map_a: assert property (psel && penable |-> pslverr == !hit)
    else $error("pslverr does not match the map");
  empty_read_a: assert property (rd_set && !hit |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_set |=> $stable(prdata))
    else $error("read data moved without a read");
  rx_on_a: assert property (presetn |=> rx_enable == 2'h3)
    else $error("reception not enabled after reset");
  retain_copy_a: assert property (ret_wr |=> retain_settings == {2{$past(pwdata[0])}})
    else $error("retain output differs from written bit");
  start_cause_a: assert property (od_request[0].start |-> $past(snd) || $past(snd, 2) || $past(snd, 3))
    else $error("sender started without a send request");
  start_pulse_a: assert property (od_request[1].start |=> !od_request[1].start)
    else $error("start longer than one cycle");
  regs_byte_a: assert property (od_request[0].start |->
    od_request[0].regs == need(od_request[0].unit_byte, cnt_reg[0])) else $error("channel 1 register count wrong");
  regs_word_a: assert property (od_request[1].start |->
    od_request[1].regs == need(od_request[1].unit_byte, cnt_reg[1])) else $error("channel 2 register count wrong");
  rx_grace_a: assert property ($rose(link_event[0].rx_active) |-> !rx_restart[0] [*8])
    else $error("timeout far earlier than one tick");
  send_c: cover property (od_request[0].start);
  restart_c: cover property (rx_restart[0]);
  refuse_c: cover property (pslverr);
endmodule
bind link_status_error_bank link_bank_props chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .link_event(link_event), .rx_enable(rx_enable), .rx_restart(rx_restart), .od_request(od_request),
  .retain_settings(retain_settings));
`default_nettype wire

// file: link_host_model.sv
// host side model: link events on demand and a timed on-demand sender
`timescale 1ns/10ps
`default_nettype none
module link_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire link_bank_pkg::od_request_t [1:0] od_request,
  output link_bank_pkg::link_event_t [1:0] link_event,
  output logic [1:0] od_done = 2'h0
);
  // ----------------
  // events and sender
  // ----------------
  int od_delay = 4;
  int left [2] = '{0, 0};
  initial link_event = '0;
  // an event lasts one cycle, except rx_active, which is held; the station bus then shows the inverse so a stale value never decodes
  task automatic send(input int ch, input link_bank_pkg::link_event_t ev);
    @(posedge pclk);
    link_event[ch] <= ev;
    @(posedge pclk);
    link_event[ch] <= '{cmd_station: ~ev.cmd_station, rx_active: ev.rx_active, default: '0};
  endtask
  // sending ends od_delay cycles after start; a long delay lets the busy flag be read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_done <= 2'h0;
      left <= '{0, 0};
    end else begin
      for (int c = 0; c < 2; c++) begin
        od_done[c] <= left[c] == 1;
        if (od_request[c].start) left[c] <= od_delay;
        else if (left[c] > 0) left[c] <= left[c] - 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: link_status_error_bank_test.sv
// self-checking bench for the link status bank with a host model on the link side
`timescale 1ns/10ps
`default_nettype none
module link_status_error_bank_test;
  // ----------------
  // signals, instances, bus tasks
  // ----------------
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic run_mode = 1'h1;
  logic power_down = 1'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready;
  logic pslverr;
  logic e;
  logic [1:0] rx_enable;
  logic [1:0] rx_restart;
  logic [1:0] od_done;
  logic [1:0] retain_settings;
  link_bank_pkg::link_event_t [1:0] link_event;
  link_bank_pkg::od_request_t [1:0] od_request;
  int fails = 0;
  int checked = 0;
  link_status_error_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_mode(run_mode),
    .power_down(power_down), .link_event(link_event), .rx_enable(rx_enable), .rx_restart(rx_restart),
    .od_request(od_request), .od_done(od_done), .retain_settings(retain_settings));
  link_host_model host (.pclk(pclk), .presetn(presetn), .od_request(od_request), .link_event(link_event),
    .od_done(od_done));
  initial begin
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string n);
    apb(1'h0, a, 32'h0);
    chk(n, q, exp);
  endtask
  function automatic logic [11:0] at(input int ch, input logic [11:0] off);
    return off + (ch == 1 ? link_bank_pkg::ch_stride : 12'h000);
  endfunction
  task automatic mode(input logic m);
    @(posedge pclk);
    run_mode <= m;
    repeat (3) @(posedge pclk);
  endtask
  // polls a pulse with a bound, since a lost pulse must not hang the run
  task automatic wait_on(input int ch, input logic done);
    int n = 0;
    while ((done ? od_done[ch] : rx_restart[ch]) !== 1'h1 && n < 800) begin
      @(posedge pclk);
      n++;
    end
    chk("awaited pulse", {31'h0, done ? od_done[ch] : rx_restart[ch]}, 32'h1);
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_regs;
    logic [15:0] p;
    for (int ch = 0; ch < 2; ch++) begin
      rd(at(ch, link_bank_pkg::off_flags), 32'h0, "flags at reset");
      rd(at(ch, link_bank_pkg::off_error_code), 32'h0, "code at reset");
      for (int i = 0; i < 5; i++) begin
        p = 16'ha5c0 + 16'(8 * ch + i);
        rd(at(ch, link_bank_pkg::off_format + 12'(4 * i)), {16'h0, link_bank_pkg::word_reset}, "word at reset");
        apb(1'h1, at(ch, link_bank_pkg::off_format + 12'(4 * i)), {16'hffff, p});
        rd(at(ch, link_bank_pkg::off_format + 12'(4 * i)), {16'h0, p}, "setting word");
      end
    end
    apb(1'h1, link_bank_pkg::off_retain, 32'h1);
    rd(link_bank_pkg::off_retain, 32'h1, "retain bit");
    chk("retain out", {30'h0, retain_settings}, 32'h3);
    apb(1'h1, link_bank_pkg::off_retain, 32'h0);
    apb(1'h0, 12'h0f0, 32'h0);
    chk("unmapped read", {q[31:1], e}, 32'h1);
  endtask
  // each fault kind on each channel: code and flag survive stop, then clear on run
  task automatic t_faults;
    logic [15:0] codes [2][3] = '{'{16'h6301, 16'h6305, 16'h6306}, '{16'h3801, 16'h3805, 16'h3806}};
    for (int ch = 0; ch < 2; ch++) begin
      // two ticks: the first tick may fall right after reception starts, so one tick gives no grace
      apb(1'h1, at(ch, link_bank_pkg::off_timeout), 32'h2);
      for (int k = 0; k < 3; k++) begin
        if (k == 0) host.send(ch, '{frame_fault: 1'h1, default: '0});
        if (k == 1) host.send(ch, '{cmd_valid: 1'h1, cmd_station: 8'hff, default: '0});
        if (k == 2) host.send(ch, '{rx_active: 1'h1, default: '0});
        if (k == 2) wait_on(ch, 1'h0);
        if (k == 2) host.send(ch, '{default: '0});
        rd(at(ch, link_bank_pkg::off_error_code), {16'h0, codes[ch][k]}, "error code");
        rd(at(ch, link_bank_pkg::off_flags), 32'h1, "link error flag");
        mode(1'h0);
        rd(at(ch, link_bank_pkg::off_error_code), {16'h0, codes[ch][k]}, "code kept");
        rd(at(ch, link_bank_pkg::off_flags), 32'h1, "flag kept");
        mode(1'h1);
        rd(at(ch, link_bank_pkg::off_error_code), 32'h0, "code after run");
        rd(at(ch, link_bank_pkg::off_flags), 32'h0, "flag after run");
      end
    end
  endtask
  task automatic t_global;
    link_bank_pkg::link_event_t g = '{cmd_valid: 1'h1, cmd_station: 8'hff, cmd_is_global_write: 1'h1,
      global_value: 1'h1, default: '0};
    host.send(1, g);
    apb(1'h1, at(1, link_bank_pkg::off_flags), 32'h0);
    rd(at(1, link_bank_pkg::off_flags), 32'h2, "global set, read only");
    rd(at(1, link_bank_pkg::off_error_code), 32'h0, "broadcast write no error");
    host.send(1, '{cmd_valid: 1'h1, cmd_station: 8'hff, cmd_is_global_write: 1'h1, default: '0});
    rd(at(1, link_bank_pkg::off_flags), 32'h0, "global cleared");
    host.send(1, g);
    @(posedge pclk);
    power_down <= 1'h1;
    @(posedge pclk);
    power_down <= 1'h0;
    rd(at(1, link_bank_pkg::off_flags), 32'h0, "off at power down");
    host.send(1, g);
    mode(1'h0);
    rd(at(1, link_bank_pkg::off_flags), 32'h0, "off at stop");
    mode(1'h1);
  endtask
  // bad count, blocked request, slow byte send on channel 1, prompt full word send on channel 2
  task automatic t_ondemand;
    apb(1'h1, link_bank_pkg::off_count, 32'h0);
    apb(1'h1, link_bank_pkg::off_control, 32'h2);
    rd(link_bank_pkg::off_flags, 32'h8, "count zero refused");
    apb(1'h1, link_bank_pkg::off_count, 32'h5);
    apb(1'h1, link_bank_pkg::off_control, 32'h3);
    rd(link_bank_pkg::off_flags, 32'h18, "send blocked");
    host.od_delay = 30;
    apb(1'h1, link_bank_pkg::off_control, 32'h5);
    apb(1'h1, link_bank_pkg::off_control, 32'h3);
    rd(link_bank_pkg::off_flags, 32'h14, "busy while sending");
    wait_on(0, 1'h1);
    rd(link_bank_pkg::off_flags, 32'h10, "busy ends");
    host.od_delay = 2;
    apb(1'h1, at(1, link_bank_pkg::off_count), 32'h100);
    apb(1'h1, at(1, link_bank_pkg::off_control), 32'h6);
    wait_on(1, 1'h1);
    rd(at(1, link_bank_pkg::off_flags), 32'h0, "word send done");
    chk("head to sender", {16'h0, od_request[1].head}, 32'ha5ca);
    chk("word register count", {16'h0, od_request[1].regs}, 32'h100);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_faults;
    t_global;
    t_ondemand;
    give_verdict;
  end
endmodule
`default_nettype wire
